// ===== core/omlc_counters.sv
/*
 * Outbound post-list and free-list occupancy counters with the outbound
 * list pointers. Secondary register access arrives as one-cycle strobes
 * with byte offset and data; primary queue-port accesses as pulses.
 * Assumes all inputs synchronous to clk and one access per port per cycle.
 */
// Operation
// [R1] Reading the post count register gives the post-list entry count in bits 15:0.
// [R2] A secondary write to the post count with bit 31 clear adds one to the count.
// [R3] A secondary write to the post count with bit 31 set loads the count from data 15:0.
// [R4] A primary read of the queue port lowers the post count by one unless it is zero.
// [R5] Reading the free count register gives the free-list entry count in bits 15:0.
// [R6] A secondary write to the free count with bit 31 clear subtracts one from the count.
// [R7] A secondary write to the free count with bit 31 set loads the count from data 15:0.
// [R8] A primary write to the queue port raises the free count by one.
// [R9] Bits 30:16 of both count registers read zero and both counts reset to zero.
// [R10] Bit 31 of both count registers only qualifies writes and reads back zero.
// [R11] The post-list head pointer steps one dword per primary queue read and wraps at its bound.
// [R12] The free-list tail pointer steps one dword per primary queue write and wraps at its bound.
// [R13] A primary queue access and a secondary write to the same counter in one cycle both take effect.
`timescale 1ns/1ps
module omlc_counters #(
	parameter int CW = omlc_pkg::COUNT_WIDTH
) (
	input  wire logic          clk,
	input  wire logic          nrst,
	input  wire logic          sec_wr,
	input  wire logic          sec_rd,
	input  wire logic [7:0]    sec_addr,
	input  wire logic [31:0]   sec_wdata,
	input  wire logic          pri_queue_rd,
	input  wire logic          pri_queue_wr,
	output logic      [31:0]   sec_rdata,
	output logic               sec_rvalid,
	output logic      [29:0]   post_head_ptr,
	output logic      [29:0]   free_tail_ptr
);
	logic [CW-1:0] post_count;
	logic [CW-1:0] free_count;
	logic [CW-1:0] next_post_count;
	logic [CW-1:0] next_free_count;
	logic [31:0]   next_sec_rdata;
	logic          next_sec_rvalid;
	logic          counter_load_select;
	logic          post_wr;
	logic          free_wr;
	logic [CW-1:0] one;

	assign one                 = {{(CW-1){1'b0}}, 1'b1};
	assign counter_load_select = sec_wdata[omlc_pkg::LOAD_SELECT_BIT];
	assign post_wr             = sec_wr && (sec_addr == omlc_pkg::POST_COUNT_OFFSET);
	assign free_wr             = sec_wr && (sec_addr == omlc_pkg::FREE_COUNT_OFFSET);

	// both sources combine into one net change so neither update is lost
	always_comb begin
		next_post_count = post_count;
		if (post_wr && counter_load_select) begin
			next_post_count = sec_wdata[CW-1:0]; // R3
			if (pri_queue_rd && sec_wdata[CW-1:0] != '0) begin
				next_post_count = sec_wdata[CW-1:0] - one; // R13
			end
		end else if (post_wr) begin
			next_post_count = post_count + one; // R2
			if (pri_queue_rd) begin
				next_post_count = post_count; // R13
			end
		end else if (pri_queue_rd && post_count != '0) begin
			next_post_count = post_count - one; // R4
		end
	end

	always_comb begin
		next_free_count = free_count;
		if (free_wr && counter_load_select) begin
			next_free_count = sec_wdata[CW-1:0] + (pri_queue_wr ? one : '0); // R7 R13
		end else if (free_wr) begin
			next_free_count = free_count - one + (pri_queue_wr ? one : '0); // R6 R13
		end else if (pri_queue_wr) begin
			next_free_count = free_count + one; // R8
		end
	end

	always_comb begin
		next_sec_rdata  = 32'h0000_0000;
		next_sec_rvalid = sec_rd;
		if (sec_rd && sec_addr == omlc_pkg::POST_COUNT_OFFSET) begin
			next_sec_rdata = {{(32-CW){1'b0}}, post_count}; // R1 R9 R10
		end else if (sec_rd && sec_addr == omlc_pkg::FREE_COUNT_OFFSET) begin
			next_sec_rdata = {{(32-CW){1'b0}}, free_count}; // R5 R9 R10
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			post_count <= omlc_pkg::COUNT_RESET; // R9
		end else begin
			post_count <= next_post_count;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			free_count <= omlc_pkg::COUNT_RESET; // R9
		end else begin
			free_count <= next_free_count;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sec_rdata  <= 32'h0000_0000;
			sec_rvalid <= 1'b0;
		end else begin
			sec_rdata  <= next_sec_rdata;
			sec_rvalid <= next_sec_rvalid;
		end
	end

	omlc_list_pointer #(.PTR_WIDTH(30)) u_post_head (
		.clk   (clk),
		.nrst  (nrst),
		.step  (pri_queue_rd), // R11
		.base  (omlc_pkg::POST_LIST_BASE),
		.limit (omlc_pkg::POST_LIST_LIMIT),
		.ptr   (post_head_ptr)
	);

	omlc_list_pointer #(.PTR_WIDTH(30)) u_free_tail (
		.clk   (clk),
		.nrst  (nrst),
		.step  (pri_queue_wr), // R12
		.base  (omlc_pkg::FREE_LIST_BASE),
		.limit (omlc_pkg::FREE_LIST_LIMIT),
		.ptr   (free_tail_ptr)
	);

	// a queue access and a counter write in the same cycle
	sequence post_load_with_read;
		post_wr && counter_load_select && pri_queue_rd;
	endsequence
	sequence post_incr_with_read;
		post_wr && !counter_load_select && pri_queue_rd;
	endsequence
	sequence free_load_with_write;
		free_wr && counter_load_select && pri_queue_wr;
	endsequence
	sequence free_decr_with_write;
		free_wr && !counter_load_select && pri_queue_wr;
	endsequence

	chk_post_load: assert property (@(posedge clk) disable iff (!nrst) // R3
		post_wr && counter_load_select && !pri_queue_rd |=> post_count == $past(sec_wdata[CW-1:0]))
		else $error("post count load failed");
	chk_post_incr: assert property (@(posedge clk) disable iff (!nrst) // R2
		post_wr && !counter_load_select && !pri_queue_rd |=> post_count == $past(post_count) + one)
		else $error("post count increment failed");
	chk_post_decr: assert property (@(posedge clk) disable iff (!nrst) // R4
		pri_queue_rd && !post_wr |=> post_count == ($past(post_count) == '0 ? '0 : $past(post_count) - one))
		else $error("post count decrement failed");
	chk_post_collide: assert property (@(posedge clk) disable iff (!nrst) // R13
		post_load_with_read |=> post_count == ($past(sec_wdata[CW-1:0]) == '0 ? '0 : $past(sec_wdata[CW-1:0]) - one))
		else $error("post load with queue read wrong");
	chk_post_both: assert property (@(posedge clk) disable iff (!nrst) // R13
		post_incr_with_read |=> post_count == $past(post_count))
		else $error("post count lost an update");
	chk_post_hold: assert property (@(posedge clk) disable iff (!nrst) // R2 R4
		!post_wr && !pri_queue_rd |=> post_count == $past(post_count))
		else $error("post count moved without cause");
	chk_free_load: assert property (@(posedge clk) disable iff (!nrst) // R7
		free_wr && counter_load_select && !pri_queue_wr |=> free_count == $past(sec_wdata[CW-1:0]))
		else $error("free count load failed");
	chk_free_decr: assert property (@(posedge clk) disable iff (!nrst) // R6
		free_wr && !counter_load_select && !pri_queue_wr |=> free_count == $past(free_count) - one)
		else $error("free count decrement failed");
	chk_free_incr: assert property (@(posedge clk) disable iff (!nrst) // R8
		pri_queue_wr && !free_wr |=> free_count == $past(free_count) + one)
		else $error("free count increment failed");
	chk_both_free: assert property (@(posedge clk) disable iff (!nrst) // R13
		free_decr_with_write |=> free_count == $past(free_count))
		else $error("free count lost an update");
	chk_free_collide: assert property (@(posedge clk) disable iff (!nrst) // R13
		free_load_with_write |=> free_count == $past(sec_wdata[CW-1:0]) + one)
		else $error("free load with queue write wrong");
	chk_free_hold: assert property (@(posedge clk) disable iff (!nrst) // R6 R8
		!free_wr && !pri_queue_wr |=> free_count == $past(free_count))
		else $error("free count moved without cause");

	chk_read_post: assert property (@(posedge clk) disable iff (!nrst) // R1
		sec_rd && sec_addr == omlc_pkg::POST_COUNT_OFFSET |=> sec_rdata == 32'($past(post_count)))
		else $error("post count read wrong");
	chk_read_free: assert property (@(posedge clk) disable iff (!nrst) // R5
		sec_rd && sec_addr == omlc_pkg::FREE_COUNT_OFFSET |=> sec_rdata == 32'($past(free_count)))
		else $error("free count read wrong");
	chk_read_other: assert property (@(posedge clk) disable iff (!nrst) // R9
		sec_rd && sec_addr != omlc_pkg::POST_COUNT_OFFSET && sec_addr != omlc_pkg::FREE_COUNT_OFFSET
		|=> sec_rdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	chk_upper_zero: assert property (@(posedge clk) disable iff (!nrst) // R9 R10
		sec_rvalid |-> sec_rdata[31:16] == 16'h0000)
		else $error("upper read bits not zero");
	chk_rvalid_pulse: assert property (@(posedge clk) disable iff (!nrst) // R1 R5
		sec_rd |=> sec_rvalid)
		else $error("read valid missing");
	chk_rdata_idle: assert property (@(posedge clk) disable iff (!nrst) // R1 R5
		!sec_rd |=> !sec_rvalid && sec_rdata == 32'h0000_0000)
		else $error("read data stood without a read");

	chk_head_step: assert property (@(posedge clk) disable iff (!nrst) // R11
		pri_queue_rd && post_head_ptr < omlc_pkg::POST_LIST_LIMIT |=> post_head_ptr == $past(post_head_ptr) + 30'h0000_0001)
		else $error("head pointer did not step");
	chk_head_wrap: assert property (@(posedge clk) disable iff (!nrst) // R11
		pri_queue_rd && post_head_ptr >= omlc_pkg::POST_LIST_LIMIT |=> post_head_ptr == omlc_pkg::POST_LIST_BASE)
		else $error("head pointer did not wrap");
	chk_head_hold: assert property (@(posedge clk) disable iff (!nrst) // R11
		!pri_queue_rd |=> post_head_ptr == $past(post_head_ptr))
		else $error("head pointer moved without a read");
	chk_tail_step: assert property (@(posedge clk) disable iff (!nrst) // R12
		pri_queue_wr && free_tail_ptr < omlc_pkg::FREE_LIST_LIMIT |=> free_tail_ptr == $past(free_tail_ptr) + 30'h0000_0001)
		else $error("tail pointer did not step");
	chk_tail_wrap: assert property (@(posedge clk) disable iff (!nrst) // R12
		pri_queue_wr && free_tail_ptr >= omlc_pkg::FREE_LIST_LIMIT |=> free_tail_ptr == omlc_pkg::FREE_LIST_BASE)
		else $error("tail pointer did not wrap");
	chk_tail_hold: assert property (@(posedge clk) disable iff (!nrst) // R12
		!pri_queue_wr |=> free_tail_ptr == $past(free_tail_ptr))
		else $error("tail pointer moved without a write");
endmodule

// ===== core/omlc_pkg.sv
/*
 * Package for the outbound message list counters: register offsets,
 * field positions, reset values and pointer defaults.
 * Assumes the including design decodes dword-aligned byte offsets.
 */
package omlc_pkg;
	localparam logic [7:0]  POST_COUNT_OFFSET  = 8'h60;
	localparam logic [7:0]  FREE_COUNT_OFFSET  = 8'h64;
	localparam logic [7:0]  QUEUE_PORT_OFFSET  = 8'h44;
	localparam int          COUNT_WIDTH        = 16;
	localparam int          LOAD_SELECT_BIT    = 31;
	localparam logic [15:0] COUNT_RESET        = 16'h0000;
	localparam logic [29:0] POST_LIST_BASE     = 30'h0000_0000;
	localparam logic [29:0] POST_LIST_LIMIT    = 30'h0000_00FF;
	localparam logic [29:0] FREE_LIST_BASE     = 30'h0000_0100;
	localparam logic [29:0] FREE_LIST_LIMIT    = 30'h0000_01FF;
endpackage

// ===== core/omlc_list_pointer.sv
/*
 * Dword pointer into a circular list in local memory; advances one
 * dword per step pulse and wraps from the upper bound to the base.
 * Assumes base is not above limit.
 */
`timescale 1ns/1ps
module omlc_list_pointer #(
	parameter int PTR_WIDTH = 30
) (
	input  wire logic                 clk,
	input  wire logic                 nrst,
	input  wire logic                 step,
	input  wire logic [PTR_WIDTH-1:0] base,
	input  wire logic [PTR_WIDTH-1:0] limit,
	output logic      [PTR_WIDTH-1:0] ptr
);
	logic [PTR_WIDTH-1:0] next_ptr;

	always_comb begin
		next_ptr = ptr;
		if (step) begin
			if (ptr >= limit) begin
				next_ptr = base;
			end else begin
				next_ptr = ptr + {{(PTR_WIDTH-1){1'b0}}, 1'b1};
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ptr <= '0;
		end else begin
			ptr <= next_ptr;
		end
	end
endmodule

// ===== testbench/omlc_host_model.sv
/*
 * Primary-side master model: turns each request into one queue-port pulse.
 * Assumes requests are raised one clock ahead of the wanted pulse.
 */
`timescale 1ns/1ps
module omlc_host_model (
	input  wire logic clk,
	input  wire logic rd_go,
	input  wire logic wr_go,
	output logic      pri_queue_rd = 1'b0,
	output logic      pri_queue_wr = 1'b0
);
	always @(posedge clk) begin
		pri_queue_rd <= rd_go;
		pri_queue_wr <= wr_go;
	end
endmodule

// ===== testbench/test_omlc_counters.sv
/*
 * Self-checking bench for omlc_counters against an integer model.
 * Assumes the host model delays queue requests by one clock.
 */
`timescale 1ns/1ps
module test_omlc_counters;
	logic        clk = 0, nrst = 0, sec_wr = 0, sec_rd = 0, rd_go = 0, wr_go = 0;
	logic        sec_rvalid, pri_queue_rd, pri_queue_wr;
	logic [7:0]  sec_addr = 8'h00;
	logic [31:0] sec_wdata = 32'h0000_0000, sec_rdata, r;
	logic [29:0] post_head_ptr, free_tail_ptr, hp = 30'h0000_0000, tp = 30'h0000_0000;
	int          post = 0, free = 0, miscompares = 0, cmp_count = 0, seed = 32'hd1a8;
	omlc_counters i_dut (.clk(clk), .nrst(nrst), .sec_wr(sec_wr), .sec_rd(sec_rd), .sec_addr(sec_addr),
		.sec_wdata(sec_wdata), .pri_queue_rd(pri_queue_rd), .pri_queue_wr(pri_queue_wr),
		.sec_rdata(sec_rdata), .sec_rvalid(sec_rvalid), .post_head_ptr(post_head_ptr),
		.free_tail_ptr(free_tail_ptr));
	omlc_host_model i_host (.clk(clk), .rd_go(rd_go), .wr_go(wr_go), .pri_queue_rd(pri_queue_rd),
		.pri_queue_wr(pri_queue_wr));
	initial forever #25 clk = ~clk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// queue pulse and register write land on the same edge
	task automatic op(input logic w, input logic [7:0] a, input logic [31:0] d, input logic qr, input logic qw);
		rd_go = qr;
		wr_go = qw;
		@(posedge clk) #1;
		rd_go = 0;
		wr_go = 0;
		chk({31'h0000_0000, sec_rvalid}, 32'h0000_0000);
		chk(sec_rdata, 32'h0000_0000);
		sec_wr = w;
		sec_addr = a;
		sec_wdata = d;
		@(posedge clk) #1;
		sec_wr = 0;
		if (w && a == omlc_pkg::POST_COUNT_OFFSET && !d[31]) begin
			if (!qr) post = (post + 1) % 65536;
		end else begin
			if (w && a == omlc_pkg::POST_COUNT_OFFSET) post = int'(d[15:0]);
			if (qr && post != 0) post--;
		end
		if (w && a == omlc_pkg::FREE_COUNT_OFFSET) free = d[31] ? int'(d[15:0]) : (free + 65535) % 65536;
		if (qw) free = (free + 1) % 65536;
		if (qr) hp = (hp >= omlc_pkg::POST_LIST_LIMIT) ? omlc_pkg::POST_LIST_BASE : hp + 30'h1;
		if (qw) tp = (tp >= omlc_pkg::FREE_LIST_LIMIT) ? omlc_pkg::FREE_LIST_BASE : tp + 30'h1;
		chk({2'b00, post_head_ptr}, {2'b00, hp});
		chk({2'b00, free_tail_ptr}, {2'b00, tp});
	endtask
	task automatic rd(input logic [7:0] a);
		sec_rd = 1;
		sec_addr = a;
		@(posedge clk) #1;
		sec_rd = 0;
		r = (a == omlc_pkg::POST_COUNT_OFFSET) ? 32'(post) : (a == omlc_pkg::FREE_COUNT_OFFSET) ? 32'(free) : 0;
		chk({31'h0000_0000, sec_rvalid}, 32'h0000_0001);
		chk(sec_rdata, r);
	endtask
	initial begin
		#(12000 * 50);
		miscompares++;
		end_of_test();
	end
	initial begin
		logic [31:0] d;
		logic [7:0]  wa;
		repeat (20) @(posedge clk);
		#1 nrst = 1;
		rd(omlc_pkg::POST_COUNT_OFFSET);
		op(0, 8'h00, 0, 0, 0);
		rd(omlc_pkg::FREE_COUNT_OFFSET);
		$display("reset values done");
		op(1, omlc_pkg::POST_COUNT_OFFSET, 32'h8000_0000, 1, 0);
		rd(omlc_pkg::POST_COUNT_OFFSET);
		op(1, omlc_pkg::FREE_COUNT_OFFSET, 32'h8000_FFFF, 0, 1);
		rd(omlc_pkg::FREE_COUNT_OFFSET);
		op(1, omlc_pkg::FREE_COUNT_OFFSET, 32'h7FFF_0003, 0, 0);
		rd(omlc_pkg::FREE_COUNT_OFFSET);
		$display("zero boundary done");
		for (int i = 0; i < 1200; i++) begin
			d = $random(seed);
			wa = (d[27:26] == 2'b00) ? 8'h68 : d[21] ? omlc_pkg::POST_COUNT_OFFSET : omlc_pkg::FREE_COUNT_OFFSET;
			op(d[20], wa, d, d[22], d[23]);
			rd(d[25:24] == 2'b00 ? 8'h68 : d[24] ? omlc_pkg::POST_COUNT_OFFSET : omlc_pkg::FREE_COUNT_OFFSET);
		end
		$display("random traffic done");
		nrst = 0;
		repeat (3) @(posedge clk);
		#1 nrst = 1;
		post = 0;
		free = 0;
		hp = 30'h0000_0000;
		tp = 30'h0000_0000;
		chk({2'b00, post_head_ptr}, {2'b00, hp});
		chk({2'b00, free_tail_ptr}, {2'b00, tp});
		rd(omlc_pkg::POST_COUNT_OFFSET);
		rd(omlc_pkg::FREE_COUNT_OFFSET);
		op(1, omlc_pkg::POST_COUNT_OFFSET, 32'h0000_1234, 1, 0);
		rd(omlc_pkg::POST_COUNT_OFFSET);
		$display("second reset done");
		end_of_test();
	end
endmodule
